// file: pkg/stfc_defs.svh
// Notes on behaviour
// - A writable switch enables RTS/CTS handshaking on the two-wire variant and half duplex on the four-wire variant, off after reset.
// - XON/XOFF from the line pauses transmit only while the transmit flow switch is set.
// - XON/XOFF is sent for receive data only while the receive flow switch is set.
// - In continuous mode the buffer is sent from a rising edge of the send trigger.
// - The acknowledge bit is set with that transfer and cleared when the trigger drops.
// - With rate optimisation, received data is released after about 16 idle bit times.
// - With rate optimisation, received data is released at once when the buffer is full.
// - A setting enables point-to-point line operation on the four-wire variant, off by default.
// - The fill alert flag is set while the receive FIFO holds at least the threshold count.
// - Sub-entry zero of the feature object reads as the fixed count six.
`ifndef STFC_DEFS_SVH
`define STFC_DEFS_SVH

`define STFC_IDX_FEATURE   16'h4075
`define STFC_IDX_THRESHOLD 16'h4076
`define STFC_FEATURE_COUNT 8'h06
`define STFC_SUB_COUNT     8'h00
`define STFC_SUB_HS        8'h01
`define STFC_SUB_TXFLOW    8'h02
`define STFC_SUB_RXFLOW    8'h03
`define STFC_SUB_MODE4     8'h04
`define STFC_SUB_MODE5     8'h05
`define STFC_SUB_MODE6     8'h06
`define STFC_THRESH_RESET  16'h0000
`define STFC_SW_ACK_BIT    2
`define STFC_SW_FILL_BIT   3
`define STFC_CW_TRIG_BIT   3
`define STFC_CHAR_XON      8'h11
`define STFC_CHAR_XOFF     8'h13
`define STFC_TX_DEPTH      128
`define STFC_RX_DEPTH      16
`define STFC_RX_HIGH       5'h0c
`define STFC_RX_LOW        5'h04
`define STFC_IDLE_BITS     16
`define STFC_CLK_HZ        20000000
`define STFC_BASE_BAUD     300
`define STFC_BIT_CYC_BASE  (`STFC_CLK_HZ / `STFC_BASE_BAUD)

`endif

// file: pkg/stfc_pkg.sv
package stfc_pkg;
    typedef logic [7:0]  stfc_byte_t;
    typedef logic [15:0] stfc_word_t;
    typedef enum logic [2:0] {
        STFC_TX_IDLE = 3'b001,
        STFC_TX_WAIT = 3'b010,
        STFC_TX_SEND = 3'b100
    } stfc_tx_state_t;
endpackage

// file: src/stfc_core.sv
`timescale 1ns/1ps
`include "stfc_defs.svh"

module stfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Fill side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Drain side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic      [WIDTH-1:0]           out_data,
    // Fill level
    output logic      [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0]           mem_q [DEPTH];
    logic [AW-1:0]              wr_q;
    logic [AW-1:0]              rd_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic                       push;
    logic                       pop;

    assign in_ready  = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module stfc_core #(
    parameter bit FOUR_WIRE   = 1'b0,
    parameter bit CONT_SEND   = 1'b0,
    parameter bit RATE_OPT_RO = 1'b1,
    parameter int BIT_CYC_300 = `STFC_BIT_CYC_BASE
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Object access
    input  wire logic               obj_req,
    input  wire logic               obj_wr,
    input  wire stfc_pkg::stfc_word_t obj_index,
    input  wire stfc_pkg::stfc_byte_t obj_subindex,
    input  wire stfc_pkg::stfc_word_t obj_wdata,
    output stfc_pkg::stfc_word_t    obj_rdata,
    output logic                    obj_ack,
    output logic                    obj_err,
    // Process data words
    input  wire stfc_pkg::stfc_word_t host_control_word,
    output stfc_pkg::stfc_word_t    device_status_word,
    input  wire logic [3:0]         baud_code,
    // Transmit buffer fill
    input  wire logic               tx_load_valid,
    output logic                    tx_load_ready,
    input  wire stfc_pkg::stfc_byte_t tx_load_data,
    // Received data to process image
    output logic                    pi_valid,
    input  wire logic               pi_ready,
    output stfc_pkg::stfc_byte_t    pi_data,
    // Line side byte streams
    output logic                    ser_tx_valid,
    input  wire logic               ser_tx_ready,
    output stfc_pkg::stfc_byte_t    ser_tx_data,
    input  wire logic               ser_rx_valid,
    input  wire stfc_pkg::stfc_byte_t ser_rx_data,
    // Line controls
    input  wire logic               cts_pin,
    output logic                    rts_pin,
    output logic                    half_duplex,
    output logic                    p2p_enable
);
    import stfc_pkg::*;

    logic           hs_q;
    logic           txflow_q;
    logic           rxflow_q;
    logic           mode6_q;
    stfc_word_t     thresh_q;
    stfc_word_t     rdata_q;
    logic           ack_q;
    logic           err_q;
    logic           cts_s1_q;
    logic           cts_s2_q;
    logic           trig_q;
    logic           sw_ack_q;
    logic           paused_q;
    logic           xoff_sent_q;
    logic           inj_q;
    stfc_byte_t     inj_char_q;
    logic           release_q;
    logic [20:0]    idle_q;
    logic           rx_seen_q;
    stfc_tx_state_t tx_state_q;

    logic           rts_cts_en;
    logic           cont_en;
    logic           rate_en;
    logic           feat_hit;
    logic           thr_hit;
    logic           sub_ok;
    logic           sub_rw;
    logic           trig_rise;
    logic           rx_is_ctl;
    logic           rx_in_valid;
    logic           rx_in_ready;
    logic           rx_out_valid;
    logic [4:0]     rx_count;
    logic           tx_out_valid;
    logic           tx_out_ready;
    stfc_byte_t     tx_out_data;
    logic           tx_gate;
    logic [20:0]    bit_cyc;
    logic [20:0]    gap_cyc;

    // Feature sub-entries change meaning between the two variants
    assign rts_cts_en  = !FOUR_WIRE && hs_q;
    assign half_duplex = FOUR_WIRE && hs_q;
    assign p2p_enable  = FOUR_WIRE && CONT_SEND;
    assign cont_en     = FOUR_WIRE ? RATE_OPT_RO : CONT_SEND;
    assign rate_en     = FOUR_WIRE ? mode6_q : RATE_OPT_RO;

    // Object dictionary access
    assign feat_hit = (obj_index == `STFC_IDX_FEATURE);
    assign thr_hit  = (obj_index == `STFC_IDX_THRESHOLD) && (obj_subindex == `STFC_SUB_COUNT);
    assign sub_ok   = feat_hit && (obj_subindex <= `STFC_SUB_MODE6);
    assign sub_rw   = feat_hit && (obj_subindex == `STFC_SUB_HS
                                || obj_subindex == `STFC_SUB_TXFLOW
                                || obj_subindex == `STFC_SUB_RXFLOW
                                || (FOUR_WIRE && obj_subindex == `STFC_SUB_MODE6));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hs_q     <= 1'b0;
            txflow_q <= 1'b0;
            rxflow_q <= 1'b0;
            mode6_q  <= 1'b1;
            thresh_q <= `STFC_THRESH_RESET;
        end
        else if (obj_req && obj_wr)
        begin
            if (sub_rw && obj_subindex == `STFC_SUB_HS)
            begin
                hs_q <= obj_wdata[0];
            end
            if (sub_rw && obj_subindex == `STFC_SUB_TXFLOW)
            begin
                txflow_q <= obj_wdata[0];
            end
            if (sub_rw && obj_subindex == `STFC_SUB_RXFLOW)
            begin
                rxflow_q <= obj_wdata[0];
            end
            if (sub_rw && obj_subindex == `STFC_SUB_MODE6)
            begin
                mode6_q <= obj_wdata[0];
            end
            if (thr_hit)
            begin
                thresh_q <= obj_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            ack_q <= obj_req;
            err_q <= obj_req && (obj_wr ? !(sub_rw || thr_hit) : !(sub_ok || thr_hit));
            if (obj_req && !obj_wr)
            begin
                unique case (obj_subindex)
                    `STFC_SUB_COUNT:  rdata_q <= {8'h00, `STFC_FEATURE_COUNT};
                    `STFC_SUB_HS:     rdata_q <= {15'h0000, hs_q};
                    `STFC_SUB_TXFLOW: rdata_q <= {15'h0000, txflow_q};
                    `STFC_SUB_RXFLOW: rdata_q <= {15'h0000, rxflow_q};
                    `STFC_SUB_MODE4:  rdata_q <= {15'h0000, CONT_SEND};
                    `STFC_SUB_MODE5:  rdata_q <= {15'h0000, RATE_OPT_RO};
                    `STFC_SUB_MODE6:  rdata_q <= {15'h0000, mode6_q};
                    default:          rdata_q <= '0;
                endcase
                if (thr_hit)
                begin
                    rdata_q <= thresh_q;
                end
                else if (!sub_ok)
                begin
                    rdata_q <= '0;
                end
            end
        end
    end

    assign obj_rdata = rdata_q;
    assign obj_ack   = ack_q;
    assign obj_err   = err_q;

    // Clear-to-send pin synchroniser
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cts_s1_q <= 1'b0;
            cts_s2_q <= 1'b0;
        end
        else
        begin
            cts_s1_q <= cts_pin;
            cts_s2_q <= cts_s1_q;
        end
    end

    // Receive path: flow characters are consumed, not stored, while the transmit flow switch is set
    assign rx_is_ctl   = txflow_q && (ser_rx_data == `STFC_CHAR_XON
                                   || ser_rx_data == `STFC_CHAR_XOFF);
    assign rx_in_valid = ser_rx_valid && !rx_is_ctl;

    stfc_fifo #(
        .WIDTH (8),
        .DEPTH (`STFC_RX_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_data   (ser_rx_data),
        .out_valid (rx_out_valid),
        .out_ready (pi_ready && release_q),
        .out_data  (pi_data),
        .count     (rx_count)
    );

    assign pi_valid = rx_out_valid && release_q;
    assign rts_pin  = rts_cts_en ? (rx_count < `STFC_RX_HIGH) : 1'b1;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            paused_q <= 1'b0;
        end
        else if (!txflow_q)
        begin
            paused_q <= 1'b0;
        end
        else if (ser_rx_valid && ser_rx_data == `STFC_CHAR_XOFF)
        begin
            paused_q <= 1'b1;
        end
        else if (ser_rx_valid && ser_rx_data == `STFC_CHAR_XON)
        begin
            paused_q <= 1'b0;
        end
    end

    // Idle gap of 16 bit times, bit time from the baud code
    assign bit_cyc = 21'(BIT_CYC_300) >> baud_code;
    assign gap_cyc = 21'(bit_cyc * `STFC_IDLE_BITS);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            idle_q    <= '0;
            rx_seen_q <= 1'b0;
            release_q <= 1'b0;
        end
        else
        begin
            if (ser_rx_valid)
            begin
                idle_q    <= '0;
                rx_seen_q <= 1'b1;
            end
            else if (rx_seen_q && idle_q < gap_cyc)
            begin
                idle_q <= idle_q + 1'b1;
            end
            if (!rate_en)
            begin
                release_q <= 1'b1;
            end
            else if (!rx_in_ready)
            begin
                release_q <= 1'b1;
            end
            else if (rx_seen_q && !ser_rx_valid && idle_q >= gap_cyc)
            begin
                release_q <= 1'b1;
                rx_seen_q <= 1'b0;
            end
            else if (!rx_out_valid || ser_rx_valid)
            begin
                release_q <= 1'b0;
            end
        end
    end

    // Receive flow control characters queued for the line
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            xoff_sent_q <= 1'b0;
            inj_q       <= 1'b0;
            inj_char_q  <= '0;
        end
        else if (inj_q)
        begin
            if (ser_tx_ready)
            begin
                inj_q <= 1'b0;
            end
        end
        else if (rxflow_q && !xoff_sent_q && rx_count >= `STFC_RX_HIGH)
        begin
            inj_q       <= 1'b1;
            inj_char_q  <= `STFC_CHAR_XOFF;
            xoff_sent_q <= 1'b1;
        end
        else if (xoff_sent_q && (!rxflow_q || rx_count <= `STFC_RX_LOW))
        begin
            inj_q       <= rxflow_q;
            inj_char_q  <= `STFC_CHAR_XON;
            xoff_sent_q <= 1'b0;
        end
    end

    // Transmit buffer, up to 128 bytes held for a continuous send
    stfc_fifo #(
        .WIDTH (8),
        .DEPTH (`STFC_TX_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (tx_load_valid),
        .in_ready  (tx_load_ready),
        .in_data   (tx_load_data),
        .out_valid (tx_out_valid),
        .out_ready (tx_out_ready),
        .out_data  (tx_out_data),
        .count     ()
    );

    assign trig_rise = host_control_word[`STFC_CW_TRIG_BIT] && !trig_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trig_q     <= 1'b0;
            sw_ack_q   <= 1'b0;
            tx_state_q <= STFC_TX_IDLE;
        end
        else
        begin
            trig_q <= host_control_word[`STFC_CW_TRIG_BIT];
            if (!host_control_word[`STFC_CW_TRIG_BIT])
            begin
                sw_ack_q <= 1'b0;
            end
            else if (cont_en && trig_rise)
            begin
                sw_ack_q <= 1'b1;
            end
            unique case (tx_state_q)
                STFC_TX_IDLE:
                begin
                    if (cont_en)
                    begin
                        tx_state_q <= STFC_TX_WAIT;
                    end
                    else if (tx_out_valid)
                    begin
                        tx_state_q <= STFC_TX_SEND;
                    end
                end
                STFC_TX_WAIT:
                begin
                    if (!cont_en)
                    begin
                        tx_state_q <= STFC_TX_IDLE;
                    end
                    else if (trig_rise)
                    begin
                        tx_state_q <= STFC_TX_SEND;
                    end
                end
                STFC_TX_SEND:
                begin
                    if (!tx_out_valid)
                    begin
                        tx_state_q <= STFC_TX_IDLE;
                    end
                end
                default:
                begin
                    tx_state_q <= STFC_TX_IDLE;
                end
            endcase
        end
    end

    // Line transmit: flow characters first, then buffered data
    assign tx_gate      = (tx_state_q == STFC_TX_SEND) && !paused_q
                          && !(rts_cts_en && !cts_s2_q);
    assign ser_tx_valid = inj_q || (tx_gate && tx_out_valid);
    assign ser_tx_data  = inj_q ? inj_char_q : tx_out_data;
    assign tx_out_ready = !inj_q && tx_gate && ser_tx_ready;

    // Status word carries the acknowledge and fill alert bits
    always_comb
    begin
        device_status_word                    = '0;
        device_status_word[`STFC_SW_ACK_BIT]  = sw_ack_q;
        device_status_word[`STFC_SW_FILL_BIT] = ({11'h000, rx_count} >= thresh_q);
    end
endmodule

// file: testbench/stfc_core_monitor.sv
`timescale 1ns/1ps
module stfc_core_checker #(
    parameter bit FOUR_WIRE   = 1'b0,
    parameter bit CONT_SEND   = 1'b0,
    parameter bit RATE_OPT_RO = 1'b1
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Object access
    input wire logic                 obj_req,
    input wire logic                 obj_wr,
    input wire stfc_pkg::stfc_word_t obj_index,
    input wire stfc_pkg::stfc_byte_t obj_subindex,
    input wire stfc_pkg::stfc_word_t obj_rdata,
    input wire logic                 obj_ack,
    input wire logic                 obj_err,
    // Process data and line controls
    input wire stfc_pkg::stfc_word_t host_control_word,
    input wire stfc_pkg::stfc_word_t device_status_word,
    input wire logic                 p2p_enable
);
    import stfc_pkg::*;
    localparam bit CONT = FOUR_WIRE ? RATE_OPT_RO : CONT_SEND;
    logic feat_wr;
    assign feat_wr = obj_req && obj_wr && obj_index == 16'h4075;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_trig_rise;
        !host_control_word[3] ##1 host_control_word[3];
    endsequence
    sequence s_count_read;
        obj_req && !obj_wr && obj_index == 16'h4075 && obj_subindex == 8'h00;
    endsequence
    a_ack_follows_req: assert property (obj_req |=> obj_ack)
        else $error("access not answered");
    a_ack_needs_req: assert property (obj_ack |-> $past(obj_req))
        else $error("answer without access");
    a_count_reads_six: assert property (s_count_read |=> obj_rdata == 16'h0006 && !obj_err)
        else $error("entry count wrong");
    a_count_write_err: assert property (feat_wr && obj_subindex == 8'h00 |=> obj_err)
        else $error("count write accepted");
    a_ro_write_err: assert property (feat_wr && obj_subindex inside {8'h04, 8'h05} |=> obj_err)
        else $error("fixed entry write accepted");
    a_bad_index_err: assert property (obj_req && !(obj_index inside {16'h4075, 16'h4076})
        |=> obj_ack && obj_err)
        else $error("unknown object accepted");
    a_send_ack_rise: assert property (s_trig_rise |=> device_status_word[2] || !CONT)
        else $error("send trigger not acknowledged");
    a_send_ack_hold: assert property (device_status_word[2] && host_control_word[3]
        |=> device_status_word[2])
        else $error("acknowledge dropped early");
    a_send_ack_clear: assert property (!host_control_word[3] |=> !device_status_word[2])
        else $error("acknowledge not cleared");
    a_ack_needs_trig: assert property ($rose(device_status_word[2]) |-> $past(host_control_word[3]))
        else $error("acknowledge without trigger");
    a_p2p_fixed: assert property (p2p_enable == (FOUR_WIRE && CONT_SEND))
        else $error("point to point setting wrong");
endmodule
bind stfc_core stfc_core_checker #(
    .FOUR_WIRE(FOUR_WIRE), .CONT_SEND(CONT_SEND), .RATE_OPT_RO(RATE_OPT_RO)
) chk_u (
    .clk(clk), .rst(rst), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_subindex(obj_subindex), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .host_control_word(host_control_word),
    .device_status_word(device_status_word), .p2p_enable(p2p_enable)
);

// file: testbench/stfc_ctrl_model.sv
`timescale 1ns/1ps
module stfc_ctrl_model (
    // Clock
    input  wire logic                 clk,
    // Status and fill feedback
    input  wire stfc_pkg::stfc_word_t device_status_word,
    input  wire logic                 tx_load_ready,
    // Control word and buffer fill
    output stfc_pkg::stfc_word_t      host_control_word,
    output logic                      tx_load_valid,
    output stfc_pkg::stfc_byte_t      tx_load_data
);
    import stfc_pkg::*;
    logic rdy_s;
    initial
    begin
        host_control_word = 16'h0000;
        tx_load_valid = 1'b0;
        tx_load_data = 8'h00;
    end
    // Ready as the next rising edge will see it
    always @(negedge clk) rdy_s = tx_load_ready;
    // Called just after a rising edge
    task automatic load_bytes(input int n, input stfc_byte_t base);
        host_control_word[15:8] <= 8'(n);
        for (int i = 0; i < n && i < 128; i++)
        begin
            tx_load_valid <= 1'b1;
            tx_load_data <= stfc_byte_t'(base + i);
            @(posedge clk);
            while (!rdy_s) @(posedge clk);
        end
        tx_load_valid <= 1'b0;
        tx_load_data <= ~tx_load_data;
        host_control_word[0] <= ~host_control_word[0];
    endtask
    task automatic trigger_send(output logic acked);
        acked = 1'b0;
        host_control_word <= 16'h0008;
        for (int i = 0; i < 8 && !acked; i++)
        begin
            @(negedge clk);
            acked = device_status_word[2];
            @(posedge clk);
        end
        host_control_word <= 16'h0000;
    endtask
endmodule

// file: testbench/stfc_core_test.sv
`timescale 1ns/1ps
module stfc_core_test;
    import stfc_pkg::*;
    logic       clk, rst, obj_req, obj_wr, obj_ack, obj_err, tx_load_valid, tx_load_ready;
    logic       pi_valid, pi_ready, ser_tx_valid, ser_tx_ready, ser_rx_valid, cts_pin;
    logic       rts_pin, half_duplex, p2p_enable, acked;
    logic [3:0] baud_code;
    stfc_word_t obj_index, obj_wdata, obj_rdata, hcw, dsw;
    stfc_byte_t obj_subindex, tx_load_data, pi_data, ser_tx_data, ser_rx_data;
    stfc_byte_t txq[$];
    int         n_mismatch, n_tests, cyc;

    stfc_core #(.CONT_SEND(1'b1), .BIT_CYC_300(8)) dut_u (
        .clk(clk), .rst(rst), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_subindex(obj_subindex), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .host_control_word(hcw),
        .device_status_word(dsw), .baud_code(baud_code), .tx_load_valid(tx_load_valid),
        .tx_load_ready(tx_load_ready), .tx_load_data(tx_load_data), .pi_valid(pi_valid),
        .pi_ready(pi_ready), .pi_data(pi_data), .ser_tx_valid(ser_tx_valid),
        .ser_tx_ready(ser_tx_ready), .ser_tx_data(ser_tx_data), .ser_rx_valid(ser_rx_valid),
        .ser_rx_data(ser_rx_data), .cts_pin(cts_pin), .rts_pin(rts_pin),
        .half_duplex(half_duplex), .p2p_enable(p2p_enable)
    );
    stfc_ctrl_model ctl_u (
        .clk(clk), .device_status_word(dsw), .tx_load_ready(tx_load_ready),
        .host_control_word(hcw), .tx_load_valid(tx_load_valid), .tx_load_data(tx_load_data)
    );

    always #25 clk = ~clk;
    // Line side always ready, so each valid cycle is one byte
    always @(negedge clk) if (ser_tx_valid) txq.push_back(ser_tx_data);

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic obj(input logic wr, input stfc_word_t idx, input stfc_byte_t sub,
                       input stfc_word_t wd, input logic e);
        @(posedge clk);
        obj_req <= 1'b1;
        obj_wr <= wr;
        obj_index <= idx;
        obj_subindex <= sub;
        obj_wdata <= wd;
        @(posedge clk);
        obj_req <= 1'b0;
        obj_wdata <= ~wd;
        @(negedge clk);
        chk("obj_ack", 16'h0001, {15'h0000, obj_ack});
        chk("obj_err", {15'h0000, e}, {15'h0000, obj_err});
    endtask
    task automatic rd(input stfc_word_t idx, input stfc_byte_t sub, input stfc_word_t exp);
        obj(1'b0, idx, sub, 16'h0000, 1'b0);
        chk("obj_rdata", exp, obj_rdata);
    endtask
    task automatic rx_burst(input int n, input stfc_byte_t base);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            ser_rx_valid <= 1'b1;
            ser_rx_data <= stfc_byte_t'(base + i);
        end
        @(posedge clk);
        ser_rx_valid <= 1'b0;
        ser_rx_data <= ~ser_rx_data;
    endtask
    task automatic drain(input int n, input stfc_byte_t base);
        int k;
        @(posedge clk);
        pi_ready <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            do @(negedge clk); while (!pi_valid && ++k < 40);
            chk("pi_data", {8'h00, stfc_byte_t'(base + i)}, {8'h00, pi_data});
            @(posedge clk);
        end
        pi_ready <= 1'b0;
    endtask

    initial
    begin
        {clk, obj_req, obj_wr, pi_ready, ser_rx_valid} = '0;
        {rst, ser_tx_ready, cts_pin} = '1;
        {obj_index, obj_wdata, obj_subindex, ser_rx_data, baud_code} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(16'h4075, 8'h00, 16'h0006);
        rd(16'h4075, 8'h01, 16'h0000);
        rd(16'h4075, 8'h02, 16'h0000);
        rd(16'h4075, 8'h03, 16'h0000);
        rd(16'h4076, 8'h00, 16'h0000);
        chk("fill flag", 16'h0001, {15'h0000, dsw[3]});
        obj(1'b1, 16'h4075, 8'h00, 16'h0001, 1'b1);
        obj(1'b1, 16'h4075, 8'h04, 16'h0001, 1'b1);
        obj(1'b0, 16'h4077, 8'h00, 16'h0000, 1'b1);
        for (int s = 1; s < 4; s++)
        begin
            obj(1'b1, 16'h4075, 8'(s), 16'h0001, 1'b0);
            rd(16'h4075, 8'(s), 16'h0001);
        end
        chk("half_duplex", 16'h0000, {15'h0000, half_duplex});
        obj(1'b1, 16'h4076, 8'h00, 16'h0010, 1'b0);
        rd(16'h4076, 8'h00, 16'h0010);
        chk("fill flag", 16'h0000, {15'h0000, dsw[3]});
        @(posedge clk);
        baud_code <= 4'h3;
        txq.delete();
        rx_burst(16, 8'h20);
        repeat (3) @(negedge clk);
        chk("pi_valid full", 16'h0001, {15'h0000, pi_valid});
        chk("rts_pin", 16'h0000, {15'h0000, rts_pin});
        chk("fill flag", 16'h0001, {15'h0000, dsw[3]});
        drain(16, 8'h20);
        repeat (4) @(negedge clk);
        chk("fill flag", 16'h0000, {15'h0000, dsw[3]});
        chk("rts_pin", 16'h0001, {15'h0000, rts_pin});
        chk("flow count", 16'h0002, 16'(txq.size()));
        chk("pause char", 16'h0013, {8'h00, txq[0]});
        chk("resume char", 16'h0011, {8'h00, txq[1]});
        rx_burst(1, 8'h55);
        repeat (10) @(negedge clk);
        chk("pi_valid gap", 16'h0000, {15'h0000, pi_valid});
        repeat (15) @(negedge clk);
        chk("pi_valid gap", 16'h0001, {15'h0000, pi_valid});
        drain(1, 8'h55);
        rx_burst(1, 8'h13);
        rx_burst(1, 8'h41);
        rx_burst(1, 8'h11);
        repeat (25) @(posedge clk);
        drain(1, 8'h41);
        @(negedge clk);
        chk("pi_valid", 16'h0000, {15'h0000, pi_valid});
        txq.delete();
        @(posedge clk);
        cts_pin <= 1'b0;
        ctl_u.load_bytes(4, 8'ha0);
        repeat (5) @(posedge clk);
        chk("early send", 16'h0000, 16'(txq.size()));
        ctl_u.trigger_send(acked);
        chk("send ack", 16'h0001, {15'h0000, acked});
        repeat (8) @(negedge clk);
        chk("cts hold", 16'h0000, 16'(txq.size()));
        @(posedge clk);
        cts_pin <= 1'b1;
        repeat (8) @(negedge clk);
        chk("sent count", 16'h0004, 16'(txq.size()));
        for (int i = 0; i < 4 && i < txq.size(); i++)
            chk("sent byte", {8'h00, stfc_byte_t'(8'ha0 + i)}, {8'h00, txq[i]});
        chk("send ack", 16'h0000, {15'h0000, dsw[2]});
        final_report();
    end
endmodule
